//--- core/hpsl_consts.svh
`ifndef HPSL_CONSTS_SVH
`define HPSL_CONSTS_SVH

// register byte offsets
`define HPSL_OFF_SLOT_CAP     12'h0c4
`define HPSL_OFF_SLOT_CTLSTS  12'h0c8
`define HPSL_OFF_LINK_CFG0    12'h0cc
`define HPSL_OFF_LINK_CFG1    12'h0d0
`define HPSL_OFF_IRQ_STATUS   12'h0e0
`define HPSL_OFF_IRQ_MASK     12'h0e4
`define HPSL_OFF_SLOT_INPUT   12'h0e8

// slot capabilities tail field positions
`define HPSL_CAP_HP_CAPABLE   6
`define HPSL_CAP_PWR_VAL_LSB  7
`define HPSL_CAP_PWR_SCL_LSB  15

// slot control reset and writable mask
`define HPSL_SLOT_CTL_RESET   16'h0000
`define HPSL_SLOT_CTL_MASK    16'h07ff

// link configuration 0 and 1 masks and resets
`define HPSL_CFG0_RESET       32'h0400_1060
`define HPSL_CFG0_MASK        32'hffff_1fff
`define HPSL_CFG1_RESET       32'h0000_0000
`define HPSL_CFG1_MASK        32'hffff_03ff

// slot status event count and state positions
`define HPSL_NUM_EVENTS       5
`define HPSL_STS_EVENT_LSB    16
`define HPSL_STS_LATCH_BIT    21
`define HPSL_STS_PRES_BIT     22

`endif

//--- core/hpsl_pkg.sv
package hpsl_pkg;
    typedef enum logic [1:0] {
        HPSL_IDLE,
        HPSL_ACCESS
    } hpsl_phase_t;

    typedef struct packed {
        logic [4:0] events;
        logic [4:0] clear;
    } hpsl_evt_bus_t;
endpackage

//--- core/hpsl_evt_if.sv
`timescale 1ns/100ps
interface hpsl_evt_if;
    import hpsl_pkg::*;
    logic [4:0] pulse;
    logic [4:0] clear;
    logic [4:0] sticky;
    modport bank (output pulse, output clear, input sticky);
    modport flags (input pulse, input clear, output sticky);
endinterface

//--- core/hpsl_evt_flags.sv
`timescale 1ns/100ps
`include "hpsl_consts.svh"
module hpsl_evt_flags
    import hpsl_pkg::*;
(
    input wire logic    clk,
    input wire logic    rst_n,
    hpsl_evt_if.flags   evt
);
    typedef struct packed {
        logic [4:0] sticky;
    } hpsl_flag_state_t;

    hpsl_flag_state_t st_reg;
    hpsl_flag_state_t st_next;

    genvar g;
    logic [4:0] bit_next;
    generate
        for (g = 0; g < `HPSL_NUM_EVENTS; g++) begin : g_flag
            // a new event in the clearing cycle must survive
            assign bit_next[g] = evt.pulse[g] | (st_reg.sticky[g] & ~evt.clear[g]);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.sticky = bit_next;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign evt.sticky = st_reg.sticky;

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        (evt.pulse[0] && evt.clear[0]) |=> evt.sticky[0])
        else $error("event lost while clearing");
endmodule

//--- core/hpsl_regs.sv
`timescale 1ns/100ps
`include "hpsl_consts.svh"
module hpsl_regs
    import hpsl_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        HOTPLUG_STRAP,
    input  wire logic [11:0] PADDR,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    input  wire logic [4:0]  SLOT_EVENTS,
    input  wire logic        RETENTION_LATCH_STATE,
    input  wire logic        PRESENCE_STATE,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    output logic [15:0]      SLOT_CONTROL,
    output logic [31:0]      LINK_CFG0,
    output logic [31:0]      LINK_CFG1
);
    typedef struct packed {
        hpsl_phase_t phase;
        logic        hp_capable;
        logic        strap_taken;
        logic [15:0] slot_control;
        logic [6:0]  slot_state;
        logic [31:0] cfg0;
        logic [31:0] cfg1;
        logic [4:0]  irq_mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } hpsl_state_t;

    hpsl_state_t st_reg;
    hpsl_state_t st_next;

    hpsl_evt_if evt_bus ();

    hpsl_evt_flags u_flags (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .evt   (evt_bus)
    );

    logic        setup_cyc;
    logic        wr_cyc;
    logic        rd_cyc;
    logic        addr_ok;
    logic [31:0] byte_mask;
    logic [31:0] rd_word;
    logic [31:0] cap_word;
    logic [4:0]  ev_clear;

    assign setup_cyc = PSEL && !PENABLE && st_reg.phase == HPSL_IDLE;
    assign wr_cyc    = setup_cyc && PWRITE;
    assign rd_cyc    = setup_cyc && !PWRITE;
    assign byte_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

    always_comb begin
        cap_word = 32'h0000_0000;
        // capable bit follows the strap caught after reset
        cap_word[`HPSL_CAP_HP_CAPABLE] = st_reg.hp_capable;
        cap_word[`HPSL_CAP_PWR_VAL_LSB +: 8] = 8'h00;
        cap_word[`HPSL_CAP_PWR_SCL_LSB +: 2] = 2'h0;
    end

    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (PADDR)
            `HPSL_OFF_SLOT_CAP: begin
                rd_word = cap_word;
            end
            `HPSL_OFF_SLOT_CTLSTS: begin
                rd_word = {9'h000, st_reg.slot_state[6:5], evt_bus.sticky,
                           st_reg.slot_control & `HPSL_SLOT_CTL_MASK};
            end
            `HPSL_OFF_LINK_CFG0: begin
                rd_word = st_reg.cfg0 & `HPSL_CFG0_MASK;
            end
            `HPSL_OFF_LINK_CFG1: begin
                rd_word = st_reg.cfg1 & `HPSL_CFG1_MASK;
            end
            `HPSL_OFF_IRQ_STATUS: begin
                rd_word = {27'h0000000, evt_bus.sticky};
            end
            `HPSL_OFF_IRQ_MASK: begin
                rd_word = {27'h0000000, st_reg.irq_mask};
            end
            `HPSL_OFF_SLOT_INPUT: begin
                rd_word = {25'h0000000, st_reg.slot_state};
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // a read of the status words clears the events it returned
    always_comb begin
        ev_clear = 5'h00;
        if (rd_cyc && (PADDR == `HPSL_OFF_IRQ_STATUS || PADDR == `HPSL_OFF_SLOT_CTLSTS)) begin
            ev_clear = evt_bus.sticky;
        end
    end

    assign evt_bus.pulse = SLOT_EVENTS;
    assign evt_bus.clear = ev_clear;

    always_comb begin
        st_next = st_reg;
        st_next.slot_state = {PRESENCE_STATE, RETENTION_LATCH_STATE, evt_bus.sticky};
        if (!st_reg.strap_taken) begin
            st_next.hp_capable  = HOTPLUG_STRAP;
            st_next.strap_taken = 1'b1;
        end
        st_next.irq = |(evt_bus.sticky & st_reg.irq_mask);
        case (st_reg.phase)
            HPSL_IDLE: begin
                st_next.pready = 1'b0;
                if (setup_cyc) begin
                    st_next.phase   = HPSL_ACCESS;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = !addr_ok;
                    st_next.prdata  = rd_cyc ? rd_word : 32'h0000_0000;
                    if (wr_cyc) begin
                        case (PADDR)
                            `HPSL_OFF_SLOT_CTLSTS: begin
                                st_next.slot_control = ((st_reg.slot_control & ~byte_mask[15:0])
                                    | (PWDATA[15:0] & byte_mask[15:0])) & `HPSL_SLOT_CTL_MASK;
                            end
                            `HPSL_OFF_LINK_CFG0: begin
                                st_next.cfg0 = ((st_reg.cfg0 & ~byte_mask)
                                    | (PWDATA & byte_mask)) & `HPSL_CFG0_MASK;
                            end
                            `HPSL_OFF_LINK_CFG1: begin
                                st_next.cfg1 = ((st_reg.cfg1 & ~byte_mask)
                                    | (PWDATA & byte_mask)) & `HPSL_CFG1_MASK;
                            end
                            `HPSL_OFF_IRQ_MASK: begin
                                if (PSTRB[0]) begin
                                    st_next.irq_mask = PWDATA[4:0];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            HPSL_ACCESS: begin
                st_next.phase   = HPSL_IDLE;
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
            end
            default: begin
                st_next.phase = HPSL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            st_reg              <= '0;
            st_reg.phase        <= HPSL_IDLE;
            st_reg.slot_control <= `HPSL_SLOT_CTL_RESET;
            st_reg.cfg0         <= `HPSL_CFG0_RESET;
            st_reg.cfg1         <= `HPSL_CFG1_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA       = st_reg.prdata;
    assign PREADY       = st_reg.pready;
    assign PSLVERR      = st_reg.pslverr;
    assign IRQ          = st_reg.irq;
    assign SLOT_CONTROL = st_reg.slot_control;
    assign LINK_CFG0    = st_reg.cfg0;
    assign LINK_CFG1    = st_reg.cfg1;

    cap_strap_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(st_reg.strap_taken) |-> st_reg.hp_capable == $past(HOTPLUG_STRAP))
        else $error("capable bit differs from strap");

    cap_power_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (rd_cyc && PADDR == `HPSL_OFF_SLOT_CAP) |=> PRDATA[14:7] == 8'h00)
        else $error("power limit value not zero");

    cap_scale_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (rd_cyc && PADDR == `HPSL_OFF_SLOT_CAP) |=> PRDATA[16:15] == 2'h0)
        else $error("power limit scale not zero");

    ctl_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_SLOT_CTLSTS && PSTRB[0])
        |=> SLOT_CONTROL[4:0] == $past(PWDATA[4:0]))
        else $error("event enables not written");

    ctl_reserved_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        SLOT_CONTROL[15:11] == 5'h00)
        else $error("slot control reserved bits set");

    cfg_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_LINK_CFG0 && PSTRB[0])
        ##1 (PREADY && PENABLE) |-> LINK_CFG0[4:0] == $past(PWDATA[4:0]))
        else $error("link enables not written");

    cfg_reset_a: assert property (@(posedge CORE_CLK)
        $rose(RESET_N) |-> LINK_CFG0[7:5] == 3'h3 && LINK_CFG0[12:8] == 5'h10)
        else $error("training counts reset wrong");

    cfg_reserved_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        LINK_CFG0[15:13] == 3'h0 && LINK_CFG1[15:10] == 6'h00)
        else $error("link config reserved bits set");

    irq_level_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        |(evt_bus.sticky & st_reg.irq_mask) |=> IRQ)
        else $error("interrupt missing for unmasked event");

    // the capable bit must not drift once the strap has been caught
    strap_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        st_reg.strap_taken |=> $stable(st_reg.hp_capable))
        else $error("capable bit changed after capture");

    cap_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (rd_cyc && PADDR == `HPSL_OFF_SLOT_CAP) |=> PRDATA[6] == $past(st_reg.hp_capable))
        else $error("capable bit not returned on read");

    ctl_indicator_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_SLOT_CTLSTS && PSTRB[1:0] == 2'h3)
        |=> SLOT_CONTROL[10:5] == $past(PWDATA[10:5]))
        else $error("indicator controls not written");

    sts_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (rd_cyc && PADDR == `HPSL_OFF_SLOT_CTLSTS)
        |=> PRDATA[20:16] == $past(evt_bus.sticky) && PRDATA[31:23] == 9'h000)
        else $error("slot status read wrong");

    cfg_counts_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_LINK_CFG0 && PSTRB[1:0] == 2'h3)
        |=> LINK_CFG0[12:5] == $past(PWDATA[12:5]))
        else $error("training counts not written");

    cfg_timer_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_LINK_CFG0 && PSTRB[3:2] == 2'h3)
        |=> LINK_CFG0[31:16] == $past(PWDATA[31:16]))
        else $error("entry timer not written");

    cfg1_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && PADDR == `HPSL_OFF_LINK_CFG1 && PSTRB == 4'hf)
        |=> LINK_CFG1 == ($past(PWDATA) & `HPSL_CFG1_MASK))
        else $error("lifetime timers not written");

    cfg1_reset_a: assert property (@(posedge CORE_CLK)
        $rose(RESET_N) |-> LINK_CFG1 == 32'h0000_0000 && SLOT_CONTROL == 16'h0000)
        else $error("lifetime timers or slot control reset wrong");

    pready_answer_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        setup_cyc |=> PREADY)
        else $error("no ready after setup");

    pready_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    slverr_map_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (setup_cyc && !addr_ok) |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");

    // a refused write must leave slot control and both link configuration registers alone
    ro_nowrite_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_cyc && !addr_ok) |=> $stable(SLOT_CONTROL) && $stable(LINK_CFG0)
        && $stable(LINK_CFG1))
        else $error("refused write changed a register");

    irq_drop_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !(|(evt_bus.sticky & st_reg.irq_mask)) |=> !IRQ)
        else $error("interrupt high with nothing pending");
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
    import hpsl_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic        strap    = 1'b1;
    logic [11:0] paddr    = 12'h000;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [3:0]  pstrb    = 4'h0;
    logic [4:0]  events   = 5'h00;
    logic        latch_st = 1'b0;
    logic        pres_st  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [15:0] slot_ctl;
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] rd;
    logic [31:0] d;
    logic [3:0]  s;
    logic [4:0]  ev;
    logic        err;
    logic [11:0] ad [3]   = '{12'h0c8, 12'h0cc, 12'h0d0};
    logic [31:0] mk [3]   = '{32'h0000_07ff, 32'hffff_1fff, 32'hffff_03ff};
    logic [31:0] sh [3]   = '{32'h0000_0000, 32'h0400_1060, 32'h0000_0000};
    int          n_fail   = 0;
    int          compares = 0;
    int          cycles   = 0;

    hpsl_regs u_dut (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .HOTPLUG_STRAP(strap),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PSTRB(pstrb), .SLOT_EVENTS(events),
        .RETENTION_LATCH_STATE(latch_st), .PRESENCE_STATE(pres_st),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .SLOT_CONTROL(slot_ctl), .LINK_CFG0(cfg0), .LINK_CFG1(cfg1)
    );

    always #20 core_clk = ~core_clk;

    // a hung handshake ends here rather than in an endless wait
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one edge passes first so psel is never assigned twice in a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input string nm);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(nm, exp, rd & m);
    endtask

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] st, input logic [31:0] m);
        logic [31:0] be;
        be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & m;
        return (o & ~be) | (w & be);
    endfunction

    task automatic post_reset(input logic hp);
        reset_n <= 1'b0;
        strap <= hp;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rdc(12'h0c4, 32'h0001_ffc0, {25'h0, hp, 6'h0}, "slot_cap");
        rdc(12'h0cc, 32'hffff_ffff, 32'h0400_1060, "link_cfg0_rst");
    endtask

    initial begin
        void'($urandom(2));
        post_reset(1'b1);
        rdc(12'h0c8, 32'hffff_ffff, 32'h0000_0000, "slot_ctlsts_rst");
        rdc(12'h0d0, 32'hffff_ffff, 32'h0000_0000, "link_cfg1_rst");
        apb(1'b1, 12'h0c4, 32'hffff_ffff, 4'hf);
        rdc(12'h0c4, 32'h0001_ffc0, 32'h0000_0040, "slot_cap_ro");
        // first pass writes all ones so reserved bits must read back zero
        for (int i = 0; i < 30; i++) begin
            d = (i < 3) ? 32'hffff_ffff : $urandom;
            s = (i < 3) ? 4'hf : 4'($urandom);
            apb(1'b1, ad[i % 3], d, s);
            sh[i % 3] = merge(sh[i % 3], d, s, mk[i % 3]);
            rdc(ad[i % 3], 32'hffff_ffff, sh[i % 3], "rw_reg");
        end
        chk("slot_ctl_port", sh[0], {16'h0, slot_ctl});
        chk("cfg0_port", sh[1], cfg0);
        chk("cfg1_port", sh[2], cfg1);
        apb(1'b1, 12'h0f0, 32'hffff_ffff, 4'hf);
        chk("pslverr", 32'h1, {31'h0, err});
        rdc(12'h0cc, 32'hffff_ffff, sh[1], "cfg0_unmapped");
        apb(1'b1, 12'h0e4, 32'h0000_0000, 4'hf);
        for (int i = 0; i < 7; i++) begin
            ev = (i < 5) ? 5'(1 << i) : 5'($urandom | 1);
            events <= ev;
            @(posedge core_clk);
            events <= 5'h00;
            repeat (3) @(posedge core_clk);
            chk("irq_masked", 32'h0, {31'h0, irq});
            apb(1'b1, 12'h0e4, {27'h0, ev}, 4'h1);
            rdc(12'h0e4, 32'h0000_001f, {27'h0, ev}, "irq_mask");
            repeat (3) @(posedge core_clk);
            chk("irq_set", 32'h1, {31'h0, irq});
            if (i[0]) begin
                rdc(12'h0e0, 32'h0000_001f, {27'h0, ev}, "irq_sts");
            end else begin
                rdc(12'h0c8, 32'h001f_0000, {11'h0, ev, 16'h0}, "slot_evt");
            end
            rdc(12'h0e0, 32'h0000_001f, 32'h0, "irq_sts_clr");
            repeat (3) @(posedge core_clk);
            chk("irq_clr", 32'h0, {31'h0, irq});
            apb(1'b1, 12'h0e4, 32'h0000_0000, 4'hf);
        end
        // events held through the clearing read: the set must win
        events <= 5'h1f;
        @(posedge core_clk);
        rdc(12'h0e0, 32'h0000_001f, 32'h0000_001f, "sts_set_wins");
        events <= 5'h00;
        rdc(12'h0e0, 32'h0000_001f, 32'h0000_001f, "sts_kept");
        rdc(12'h0e0, 32'h0000_001f, 32'h0000_0000, "sts_cleared");
        for (int i = 0; i < 4; i++) begin
            {latch_st, pres_st} <= 2'(i);
            repeat (3) @(posedge core_clk);
            rdc(12'h0c8, 32'h0060_0000, {9'h0, pres_st, latch_st, 21'h0}, "slot_state");
            rdc(12'h0e8, 32'h0000_0060, {25'h0, pres_st, latch_st, 5'h0}, "slot_input");
        end
        post_reset(1'b0);
        final_report();
    end
endmodule
